//--- shared/adcss_pkg.sv
// Constants and types for the converter scan sequencer.
// Assumes a single 25 MHz clock and a 4-bit register address port.
package adcss_pkg;

  // Widths
  localparam int ADDR_W   = 4;
  localparam int DATA_W   = 16;
  localparam int RES_BITS = 10;
  localparam int RES_PAD  = 6;
  localparam int NCH      = 8;
  localparam int CH_W     = 3;

  // Register offsets
  localparam logic [ADDR_W-1:0] CSR_OFS  = 4'h0;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h1;
  localparam logic [ADDR_W-1:0] TSEL_OFS = 4'h2;
  localparam logic [ADDR_W-1:0] RES_BASE = 4'h8;

  // Field positions
  localparam int CSR_FLAG_BIT   = 7;
  localparam int CSR_IE_BIT     = 6;
  localparam int CSR_MODE_LSB   = 4;
  localparam int CSR_SLOW_BIT   = 3;
  localparam int CSR_CH_LSB     = 0;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STBY_BIT  = 1;
  localparam int TSEL_EXT_BIT   = 0;
  localparam int TSEL_TMR_LSB   = 1;

  // Modes and timer trigger selects
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_CONT   = 2'h1;
  localparam logic [1:0] MODE_ONCE   = 2'h2;
  localparam logic [1:0] TMR_NONE    = 2'h0;
  localparam logic [1:0] TMR_A       = 2'h1;
  localparam logic [1:0] TMR_B       = 2'h2;

  // Reset values
  localparam logic [1:0]      MODE_RST = 2'h0;
  localparam logic [1:0]      TMR_RST  = 2'h0;
  localparam logic [CH_W-1:0] CH_RST   = 3'h0;
  localparam logic [RES_BITS-1:0] RES_RST = 10'h000;

  // Conversion timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int CONV_TIME_NS  = 2000;
  localparam int CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLOW_MULT     = 2;
  localparam int CONV_CYC_SLOW = CONV_CYC * SLOW_MULT;
  localparam int TCNT_W        = 7;
  localparam logic [TCNT_W-1:0] LOAD_FAST = TCNT_W'(CONV_CYC - 1);
  localparam logic [TCNT_W-1:0] LOAD_SLOW = TCNT_W'(CONV_CYC_SLOW - 1);

  typedef enum logic [0:0] {ADCSS_IDLE, ADCSS_CONV} adcss_state_t;

endpackage : adcss_pkg

//--- design/adcss_timer.sv
// Conversion time counter for one channel.
// Assumes start and abort are one-cycle pulses from the sequencer.
`timescale 1ns/100ps
module adcss_timer
  import adcss_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  input  wire logic abort,
  input  wire logic slow,
  // Status
  output logic      done
);

  logic [TCNT_W-1:0] cnt_r;
  logic              run_r;
  logic [TCNT_W-1:0] load;

  assign load = slow ? LOAD_SLOW : LOAD_FAST;
  assign done = run_r && (cnt_r == '0);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_r <= 1'b0;
      cnt_r <= '0;
    end
    else if (abort)
    begin
      run_r <= 1'b0;
    end
    else if (start)
    begin
      run_r <= 1'b1;
      cnt_r <= load;
    end
    else if (done)
    begin
      run_r <= 1'b0;
    end
    else if (run_r)
    begin
      cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule : adcss_timer

//--- design/adcss_trig.sv
// Hardware start trigger selection and edge detection.
// Assumes trigger inputs are synchronous levels; a rising edge starts.
`timescale 1ns/100ps
module adcss_trig
  import adcss_pkg::*;
(
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       rst_n,
  // Trigger sources
  input  wire logic       timer_a_trg,
  input  wire logic       timer_b_trg,
  input  wire logic       ext_trg,
  // Selection
  input  wire logic [1:0] tmr_sel,
  input  wire logic       ext_en,
  // Result
  output logic            trg
);

  logic ta_q_r;
  logic tb_q_r;
  logic ex_q_r;
  logic ta_edge;
  logic tb_edge;
  logic ex_edge;

  assign ta_edge = timer_a_trg && !ta_q_r;
  assign tb_edge = timer_b_trg && !tb_q_r;
  assign ex_edge = ext_trg && !ex_q_r;

  // Timer units picked by select, external only when enabled
  assign trg = (tmr_sel == TMR_A && ta_edge) ||
               (tmr_sel == TMR_B && tb_edge) ||
               (ext_en && ex_edge);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ta_q_r <= 1'b0;
      tb_q_r <= 1'b0;
      ex_q_r <= 1'b0;
    end
    else
    begin
      ta_q_r <= timer_a_trg;
      tb_q_r <= timer_b_trg;
      ex_q_r <= ext_trg;
    end
  end

endmodule : adcss_trig

//--- design/adcss_seq.sv
// Scan sequencer and register file of the 10-bit converter.
// Assumes the converter core holds analog_code valid at the end of the
// conversion time, for the channel shown on conv_ch.
`timescale 1ns/100ps

module adcss_seq
  import adcss_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Register port
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [DATA_W-1:0]   wr_data,
  input  wire logic                wr_en,
  input  wire logic                rd_en,
  output logic      [DATA_W-1:0]   rd_data,
  // Start triggers
  input  wire logic                timer_a_trg,
  input  wire logic                timer_b_trg,
  input  wire logic                ext_trg,
  // Converter core
  output logic                     conv_start,
  output logic      [CH_W-1:0]     conv_ch,
  input  wire logic [RES_BITS-1:0] analog_code,
  // Events
  output logic                     conv_end_irq,
  output logic                     xfer_req,
  output logic                     busy
);

  function automatic logic is_res(input logic [ADDR_W-1:0] a);
    is_res = a[ADDR_W-1] == RES_BASE[ADDR_W-1];
  endfunction : is_res

  adcss_state_t state_r;
  adcss_state_t state_nxt;

  logic                           flag_r;
  logic                           ie_r;
  logic [1:0]                     mode_r;
  logic                           slow_r;
  logic [CH_W-1:0]                cfg_ch_r;
  logic                           start_r;
  logic                           standby_r;
  logic [1:0]                     tmr_sel_r;
  logic                           ext_en_r;
  logic [CH_W-1:0]                ch_r;
  logic [NCH-1:0][RES_BITS-1:0]   res_r;
  logic [DATA_W-1:0]              rd_data_r;
  logic                           conv_start_r;
  logic [CH_W-1:0]                conv_ch_r;
  logic                           irq_r;
  logic                           xfer_r;

  logic                           flag_nxt;
  logic                           start_nxt;
  logic [CH_W-1:0]                ch_nxt;
  logic                           irq_nxt;

  // Decode
  logic csr_wr;
  logic ctrl_wr;
  logic tsel_wr;
  logic res_wr;
  logic sw_start;
  logic sw_stop;
  logic hw_trg;
  logic tmr_done;
  logic in_conv;
  logic go;
  logic abort;
  logic pass_end;
  logic again;
  logic stop;
  logic tmr_go;
  logic [DATA_W-1:0] csr_val;
  logic [DATA_W-1:0] ctrl_val;
  logic [DATA_W-1:0] tsel_val;
  logic [DATA_W-1:0] res_val;
  logic [DATA_W-1:0] rd_mux;

  assign csr_wr   = wr_en && addr == CSR_OFS;
  assign ctrl_wr  = wr_en && addr == CTRL_OFS;
  assign tsel_wr  = wr_en && addr == TSEL_OFS;
  assign res_wr   = wr_en && is_res(addr);   // Decoded to nothing
  assign sw_start = ctrl_wr && wr_data[CTRL_START_BIT];
  assign sw_stop  = ctrl_wr && !wr_data[CTRL_START_BIT];

  // Sequencing
  assign in_conv  = state_r == ADCSS_CONV;
  assign go       = !in_conv && !standby_r && !(ctrl_wr && wr_data[CTRL_STBY_BIT]) &&
                    (sw_start || hw_trg);
  assign abort    = in_conv && (standby_r || sw_stop);
  assign pass_end = in_conv && tmr_done &&
                    (mode_r == MODE_SINGLE || ch_r == cfg_ch_r);
  assign again    = mode_r == MODE_CONT && start_r;
  assign stop     = pass_end && !again && !abort;
  assign tmr_go   = go || (in_conv && tmr_done && !stop && !abort);

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ADCSS_IDLE:
      begin
        if (go)
          state_nxt = ADCSS_CONV;
      end
      ADCSS_CONV:
      begin
        if (abort || stop)
          state_nxt = ADCSS_IDLE;
      end
      default:
        state_nxt = ADCSS_IDLE;
    endcase
  end

  always_comb
  begin
    ch_nxt = ch_r;
    if (go)
      ch_nxt = (mode_r == MODE_SINGLE) ? cfg_ch_r : CH_RST;
    else if (in_conv && tmr_done)
      ch_nxt = pass_end ? CH_RST : ch_r + 1'b1;
  end

  // Clear by hardware wins over a start write in the same cycle
  always_comb
  begin
    start_nxt = start_r;
    if (standby_r || stop)
      start_nxt = 1'b0;
    else if (go)
      start_nxt = 1'b1;
    else if (sw_stop)
      start_nxt = 1'b0;
  end

  // Set by hardware wins over software clear
  assign flag_nxt = pass_end || (flag_r && !(csr_wr && !wr_data[CSR_FLAG_BIT]));
  assign irq_nxt  = flag_nxt && ie_r;

  // Read data
  assign csr_val  = {8'h00, flag_r, ie_r, mode_r, slow_r, cfg_ch_r};
  assign ctrl_val = {14'h0000, standby_r, start_r};
  assign tsel_val = {13'h0000, tmr_sel_r, ext_en_r};
  assign res_val  = {res_r[addr[CH_W-1:0]], {RES_PAD{1'b0}}};
  assign rd_mux   = !rd_en             ? 16'h0000 :
                    is_res(addr)       ? res_val  :
                    addr == CSR_OFS    ? csr_val  :
                    addr == CTRL_OFS   ? ctrl_val :
                    addr == TSEL_OFS   ? tsel_val : 16'h0000;

  adcss_timer u_timer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .start (tmr_go),
    .abort (abort),
    .slow  (slow_r),
    .done  (tmr_done)
  );

  adcss_trig u_trig (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .timer_a_trg (timer_a_trg),
    .timer_b_trg (timer_b_trg),
    .ext_trg     (ext_trg),
    .tmr_sel     (tmr_sel_r),
    .ext_en      (ext_en_r),
    .trg         (hw_trg)
  );

  // Per-channel result storage
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_res
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          res_r[g] <= RES_RST;
        else if (in_conv && tmr_done && ch_r == CH_W'(g))
          res_r[g] <= analog_code;
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ie_r      <= 1'b0;
      mode_r    <= MODE_RST;
      slow_r    <= 1'b0;
      cfg_ch_r  <= CH_RST;
      standby_r <= 1'b0;
      tmr_sel_r <= TMR_RST;
      ext_en_r  <= 1'b0;
    end
    else
    begin
      if (csr_wr)
      begin
        ie_r     <= wr_data[CSR_IE_BIT];
        mode_r   <= wr_data[CSR_MODE_LSB +: 2];
        slow_r   <= wr_data[CSR_SLOW_BIT];
        cfg_ch_r <= wr_data[CSR_CH_LSB +: CH_W];
      end
      if (ctrl_wr)
        standby_r <= wr_data[CTRL_STBY_BIT];
      if (tsel_wr)
      begin
        tmr_sel_r <= wr_data[TSEL_TMR_LSB +: 2];
        ext_en_r  <= wr_data[TSEL_EXT_BIT];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r      <= ADCSS_IDLE;
      start_r      <= 1'b0;
      flag_r       <= 1'b0;
      ch_r         <= CH_RST;
      rd_data_r    <= 16'h0000;
      conv_start_r <= 1'b0;
      conv_ch_r    <= CH_RST;
      irq_r        <= 1'b0;
      xfer_r       <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      start_r      <= start_nxt;
      flag_r       <= flag_nxt;
      ch_r         <= ch_nxt;
      rd_data_r    <= rd_mux;
      conv_start_r <= tmr_go;
      conv_ch_r    <= ch_nxt;
      irq_r        <= irq_nxt;
      xfer_r       <= pass_end;
    end
  end

  assign rd_data      = rd_data_r;
  assign conv_start   = conv_start_r;
  assign conv_ch      = conv_ch_r;
  assign conv_end_irq = irq_r;
  assign xfer_req     = xfer_r;
  assign busy         = state_r == ADCSS_CONV;

  // Checks
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  res_low_zero_a : assert property (rd_en && is_res(addr) |=> rd_data[5:0] == 6'h00)
    else $error("result low bits not zero");
  res_ro_a : assert property (res_wr && !tmr_done |=> $stable(res_r))
    else $error("result changed by write");
  res_own_a : assert property (in_conv && tmr_done |=> res_r[$past(ch_r)] == $past(analog_code))
    else $error("result not in own channel");
  conv_time_a : assert property (disable iff (!rst_n || abort) conv_start && !slow_r |-> ##49 tmr_done)
    else $error("conversion time wrong");
  self_stop_a : assert property (stop |=> !start_r && flag_r && !busy)
    else $error("scan end did not stop");
  single_one_a : assert property (in_conv && tmr_done && mode_r == MODE_SINGLE |=> !busy && !conv_start)
    else $error("single mode ran on");
  scan_zero_a : assert property (go && mode_r != MODE_SINGLE |=> conv_ch == 3'h0 && conv_start)
    else $error("scan not from channel zero");
  cont_wrap_a : assert property (pass_end && again && !abort |=> busy && ch_r == 3'h0)
    else $error("continuous scan did not repeat");
  no_restart_a : assert property (in_conv && sw_start && !tmr_done && !standby_r |=> busy && $stable(ch_r))
    else $error("scan restarted");
  end_req_a : assert property (pass_end && ie_r |=> conv_end_irq && xfer_req ##1 !xfer_req)
    else $error("end request missing");
  standby_a : assert property (standby_r |=> !busy && !start_r)
    else $error("standby did not stop");

endmodule : adcss_seq

//--- verif/adcss_core_model.sv
// Converter core stand-in: holds one code per channel while converting.
// Assumes conv_ch stays put for the whole conversion.
`timescale 1ns/100ps
module adcss_core_model
  import adcss_pkg::*;
(
  // Clock and reset
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Sequencer side
  input  wire logic [CH_W-1:0]     conv_ch,
  input  wire logic                busy,
  input  wire logic [6:0]          code_lo,
  output logic      [RES_BITS-1:0] analog_code
);
  logic [RES_BITS-1:0] junk_r;

  // Toggling pattern while no conversion runs
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      junk_r <= 10'h155;
    else
      junk_r <= ~junk_r;
  end

  assign analog_code = busy ? {conv_ch, code_lo} : junk_r;
endmodule : adcss_core_model

//--- verif/testbench.sv
// Self-checking bench for the converter scan sequencer.
// Assumes the register map and timing of the sequencer hand-over.
`timescale 1ns/100ps
module testbench
  import adcss_pkg::*;
;
  logic                rst_n, mclk, wr_en, rd_en, timer_a_trg, timer_b_trg, ext_trg;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wr_data, rd_data;
  logic [CH_W-1:0]     conv_ch, ch_log [8];
  logic [RES_BITS-1:0] analog_code;
  logic [6:0]          code_lo;
  logic                conv_start, conv_end_irq, xfer_req, busy;
  int                  errors, tests_run, nlog, xfers, busy_cyc;

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  adcss_seq dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .timer_a_trg(timer_a_trg), .timer_b_trg(timer_b_trg), .ext_trg(ext_trg),
    .conv_start(conv_start), .conv_ch(conv_ch), .analog_code(analog_code), .conv_end_irq(conv_end_irq),
    .xfer_req(xfer_req), .busy(busy));
  adcss_core_model core_u (.mclk(mclk), .rst_n(rst_n), .conv_ch(conv_ch), .busy(busy), .code_lo(code_lo),
    .analog_code(analog_code));

  // Channel order, pass ends and busy time
  always @(posedge mclk)
  begin
    if (conv_start === 1'b1)
    begin
      if (nlog < 8)
        ch_log[nlog] = conv_ch;
      nlog++;
    end
    if (xfer_req === 1'b1)
      xfers++;
    if (busy === 1'b1)
      busy_cyc++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge mclk);
    wr_en   <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge mclk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge mclk);
    rd_en <= 1'b0;
    @(negedge mclk);
    check(rd_data, exp);
  endtask : rdchk

  function automatic logic [DATA_W-1:0] res(input int ch);
    return {3'(ch), code_lo, 6'h00};
  endfunction : res

  task automatic clr;
    @(negedge mclk);
    nlog     = 0;
    xfers    = 0;
    busy_cyc = 0;
  endtask : clr

  task automatic wait_high(output bit up);
    up = 1'b0;
    repeat (8)
    begin
      @(negedge mclk);
      if (busy === 1'b1)
        up = 1'b1;
    end
  endtask : wait_high

  task automatic wait_low(input int limit);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < limit)
    begin
      @(negedge mclk);
      n++;
    end
    check(16'(busy), 16'h0000);
  endtask : wait_low

  task automatic s_reset;
    rdchk(CSR_OFS, 16'h0000);
    rdchk(CTRL_OFS, 16'h0000);
    rdchk(TSEL_OFS, 16'h0000);
    rdchk(4'h3, 16'h0000);
    rdchk(RES_BASE, 16'h0000);
    check(16'(conv_end_irq), 16'h0000);
  endtask : s_reset

  task automatic s_single;
    bit up;
    wr(CSR_OFS, 16'h0005);
    clr;
    wr(CTRL_OFS, 16'h0001);
    wait_high(up);
    wait_low(200);
    check(16'(nlog), 16'h0001);
    check(16'(ch_log[0]), 16'h0005);
    check(16'(busy_cyc), 16'(CONV_CYC));
    rdchk(RES_BASE + 4'h5, res(5));
    rdchk(RES_BASE + 4'h4, 16'h0000);
    rdchk(CTRL_OFS, 16'h0000);
    rdchk(CSR_OFS, 16'h0085);
    check(16'(conv_end_irq), 16'h0000);
    wr(RES_BASE + 4'h5, 16'hffff);
    rdchk(RES_BASE + 4'h5, res(5));
  endtask : s_single

  task automatic s_scan;
    bit up;
    wr(CSR_OFS, 16'h0067);
    code_lo <= 7'h15;
    clr;
    wr(CTRL_OFS, 16'h0001);
    wait_high(up);
    repeat (70) @(posedge mclk);
    wr(CTRL_OFS, 16'h0001);
    wait_low(600);
    // End pulse is counted at the edge that closes it
    @(negedge mclk);
    check(16'(xfer_req), 16'h0000);
    check(16'(nlog), 16'h0008);
    check(16'(busy_cyc), 16'(8 * CONV_CYC));
    check(16'(xfers), 16'h0001);
    check(16'(conv_end_irq), 16'h0001);
    for (int i = 0; i < 8; i++)
    begin
      check(16'(ch_log[i]), 16'(i));
      rdchk(RES_BASE + 4'(i), res(i));
    end
    rdchk(CTRL_OFS, 16'h0000);
    wr(CSR_OFS, 16'h0047);
    @(negedge mclk);
    check(16'(conv_end_irq), 16'h0000);
  endtask : s_scan

  task automatic s_slow;
    bit up;
    wr(CSR_OFS, 16'h0008);
    clr;
    wr(CTRL_OFS, 16'h0001);
    wait_high(up);
    wait_low(300);
    check(16'(busy_cyc), 16'(CONV_CYC_SLOW));
  endtask : s_slow

  task automatic s_cont;
    bit up;
    int n;
    wr(CSR_OFS, 16'h0011);
    clr;
    wr(CTRL_OFS, 16'h0001);
    wait_high(up);
    n = 0;
    while (xfers < 3 && n < 1000)
    begin
      @(negedge mclk);
      n++;
    end
    check(16'(busy), 16'h0001);
    wr(CTRL_OFS, 16'h0000);
    wait_low(4);
    for (int i = 0; i < 6; i++)
      check(16'(ch_log[i]), 16'(i % 2));
  endtask : s_cont

  task automatic s_trig;
    logic [15:0] tsel_v [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0002};
    int          src_v  [5] = '{0, 0, 1, 2, 2};
    bit          exp_v  [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
    bit          up;
    for (int i = 0; i < 5; i++)
    begin
      wr(TSEL_OFS, tsel_v[i]);
      wr(CSR_OFS, 16'h0000);
      @(posedge mclk);
      ext_trg     <= (src_v[i] == 0);
      timer_a_trg <= (src_v[i] == 1);
      timer_b_trg <= (src_v[i] == 2);
      repeat (2) @(posedge mclk);
      ext_trg     <= 1'b0;
      timer_a_trg <= 1'b0;
      timer_b_trg <= 1'b0;
      wait_high(up);
      check(16'(up), 16'(exp_v[i]));
      wait_low(200);
    end
  endtask : s_trig

  task automatic s_stby;
    bit up;
    wr(CTRL_OFS, 16'h0002);
    wr(CTRL_OFS, 16'h0003);
    wait_high(up);
    check(16'(up), 16'h0000);
    wr(CSR_OFS, 16'h0027);
    wr(CTRL_OFS, 16'h0000);
    wr(CTRL_OFS, 16'h0001);
    wait_high(up);
    check(16'(up), 16'h0001);
    wr(CTRL_OFS, 16'h0002);
    wait_low(4);
    rdchk(CTRL_OFS, 16'h0002);
    rdchk(CSR_OFS, 16'h0027);
  endtask : s_stby

  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : test_done

  initial
  begin
    rst_n       = 1'b0;
    wr_en       = 1'b0;
    rd_en       = 1'b0;
    timer_a_trg = 1'b0;
    timer_b_trg = 1'b0;
    ext_trg     = 1'b0;
    addr        = '0;
    wr_data     = '0;
    code_lo     = 7'h2a;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    s_reset;
    s_single;
    s_scan;
    s_slow;
    s_cont;
    s_trig;
    s_stby;
    test_done;
  end

  // Run is under two thousand cycles; cut a hang well beyond that
  initial
  begin
    #(40 * 20000);
    errors++;
    test_done;
  end
endmodule : testbench
